//--- hdl/flag_align_pkg.sv
// constants and carrier types for the flag and alignment datapath
//
// Contract
// RL1 - negative flag copies result top bit
// RL2 - zero flag set on zero result
// RL3 - overflow flag follows signed arithmetic overflow
// RL4 - carry flag reports addition carry out
// RL5 - carry flag reports subtraction borrow out
// RL6 - shifts and rotates put outgoing bit in carry
// RL7 - bit instructions use carry as accumulator
// RL8 - bit, digit, byte, word, longword sizes
// RL9 - bit instructions select bit 0 to 7
// RL10 - decimal adjust treats byte as two digits
// RL11 - software keeps word data at even addresses
// RL12 - odd word access forced even, no error
// RL13 - instruction fetch address lowest bit ignored
// RL14 - software uses word or longword stack accesses
// RL15 - half carry at bit 3, 11, 27
// RL16 - untouched flags hold; register control instructions
// RL17 - flag width follows operand size
package flag_align_pkg;

  // ==========================================================
  // flag register layout
  localparam int FLAG_BIT_MASK  = 7;
  localparam int FLAG_BIT_USER1 = 6;
  localparam int FLAG_BIT_HALF  = 5;
  localparam int FLAG_BIT_USER0 = 4;
  localparam int FLAG_BIT_NEG   = 3;
  localparam int FLAG_BIT_ZERO  = 2;
  localparam int FLAG_BIT_OVF   = 1;
  localparam int FLAG_BIT_CARRY = 0;
  // only the interrupt mask is defined at reset; others are held at zero for determinism
  localparam logic [7:0] FLAG_RESET = 8'h80;

  // ==========================================================
  // half-carry bit positions per size
  localparam int HALF_POS_BYTE = 3;
  localparam int HALF_POS_WORD = 11;
  localparam int HALF_POS_LONG = 27;

  // ==========================================================
  // operand sizes
  typedef enum logic [1:0] {
    SIZE_BYTE = 2'b00,
    SIZE_WORD = 2'b01,
    SIZE_LONG = 2'b11
  } size_e;

  // ==========================================================
  // operations
  typedef enum logic [4:0] {
    OP_NONE  = 5'h00,
    OP_ADD   = 5'h01,
    OP_ADDX  = 5'h02,
    OP_SUB   = 5'h03,
    OP_SUBX  = 5'h04,
    OP_CMP   = 5'h05,
    OP_NEG   = 5'h06,
    OP_AND   = 5'h07,
    OP_OR    = 5'h08,
    OP_XOR   = 5'h09,
    OP_MOV   = 5'h0A,
    OP_SHL   = 5'h0B,
    OP_SHR   = 5'h0C,
    OP_SAR   = 5'h0D,
    OP_ROL   = 5'h0E,
    OP_ROR   = 5'h0F,
    OP_DAA   = 5'h10,
    OP_DAS   = 5'h11,
    OP_BLD   = 5'h12,
    OP_BST   = 5'h13,
    OP_BAND  = 5'h14,
    OP_BOR   = 5'h15,
    OP_BXOR  = 5'h16,
    OP_BSET  = 5'h17,
    OP_BCLR  = 5'h18,
    OP_BNOT  = 5'h19,
    OP_FLDC  = 5'h1A,
    OP_FANDC = 5'h1B,
    OP_FORC  = 5'h1C,
    OP_FXORC = 5'h1D
  } op_e;

  // ==========================================================
  // request from execution and result back
  typedef struct packed {
    op_e         op;
    size_e       size;
    logic [2:0]  bit_sel;
    logic [31:0] dst;
    logic [31:0] src;
  } alu_req_s;

  typedef struct packed {
    logic [31:0] value;
    logic        write;
  } alu_res_s;

endpackage

//--- hdl/flag_align_unit.sv
// flag generation, operand sizing and forced-even address alignment
`timescale 1ns/10ps
module flag_align_unit (
  input  wire logic                     mclk,
  input  wire logic                     rst,
  input  wire logic                     req_valid,
  input  wire flag_align_pkg::alu_req_s req,
  output flag_align_pkg::alu_res_s      res,
  output logic [7:0]                    condition_flags,
  input  wire logic [23:0]              mem_addr_in,
  input  wire flag_align_pkg::size_e    mem_size,
  output logic [23:0]                   mem_addr_out,
  input  wire logic [23:0]              fetch_addr_in,
  output logic [23:0]                   fetch_addr_out
);

  // ==========================================================
  // helpers
  // top bit of a value at the operand width
  function automatic logic top_bit(input logic [31:0] v, input flag_align_pkg::size_e s);
    unique case (s)
      flag_align_pkg::SIZE_BYTE: top_bit = v[7];
      flag_align_pkg::SIZE_WORD: top_bit = v[15];
      default:                   top_bit = v[31];
    endcase
  endfunction

  // value masked to the operand width
  function automatic logic [31:0] fit(input logic [31:0] v, input flag_align_pkg::size_e s);
    unique case (s)
      flag_align_pkg::SIZE_BYTE: fit = {24'h00_0000, v[7:0]};
      flag_align_pkg::SIZE_WORD: fit = {16'h0000, v[15:0]};
      default:                   fit = v;
    endcase
  endfunction

  // top-bit mask at the operand width; refills the vacated top bit of the arithmetic right shift and the right rotate
  function automatic logic [31:0] top_mask(input flag_align_pkg::size_e s);
    unique case (s)
      flag_align_pkg::SIZE_BYTE: top_mask = 32'h0000_0080;
      flag_align_pkg::SIZE_WORD: top_mask = 32'h0000_8000;
      default:                   top_mask = 32'h8000_0000;
    endcase
  endfunction

  // carry out of the operand's top bit; operands are pre-masked so no stray bits
  function automatic logic carry_out(input logic [32:0] s, input flag_align_pkg::size_e z);
    unique case (z)
      flag_align_pkg::SIZE_BYTE: carry_out = s[8];
      flag_align_pkg::SIZE_WORD: carry_out = s[16];
      default:                   carry_out = s[32];
    endcase
  endfunction

  // carry into bit position p+1 of a sum, used for half carry
  function automatic logic carry_at(input logic [31:0] a, input logic [31:0] b,
                                    input logic [31:0] r, input int p);
    carry_at = a[p+1] ^ b[p+1] ^ r[p+1];
  endfunction

  // ==========================================================
  // combinational result and flags
  logic [7:0]  next_flags;
  logic [31:0] a;
  logic [31:0] b;
  logic [32:0] sum;
  logic [31:0] r;
  logic [31:0] bop;
  logic        cin;
  logic        sub;
  logic        arith;
  logic        logic_op;
  logic        sh_out;
  logic        do_write;
  logic        shift_op;
  logic        bit_val;
  logic [7:0]  bmask;
  logic [7:0]  dadj;
  int          hpos;

  always_comb begin
    // defaults: every flag holds and nothing is stored
    next_flags = condition_flags;                           // [RL16]
    a          = fit(req.dst, req.size);                    // [RL8] [RL17]
    b          = fit(req.src, req.size);
    sub        = 1'b0;
    cin        = 1'b0;
    arith      = 1'b0;
    logic_op   = 1'b0;
    shift_op   = 1'b0;
    do_write   = 1'b0;
    sh_out     = 1'b0;
    r          = 32'h0000_0000;
    bop        = b;
    sum        = 33'h0_0000_0000;
    dadj       = 8'h00;
    // bit ops see only the low byte; a 3-bit select cannot leave it
    bmask      = 8'h01 << req.bit_sel;                      // [RL9]
    bit_val    = req.dst[req.bit_sel];                      // [RL9]
    // nibble boundary feeding the half carry, by operand size
    unique case (req.size)
      flag_align_pkg::SIZE_BYTE: hpos = flag_align_pkg::HALF_POS_BYTE;
      flag_align_pkg::SIZE_WORD: hpos = flag_align_pkg::HALF_POS_WORD;
      default:                   hpos = flag_align_pkg::HALF_POS_LONG;
    endcase
    // per-operation result and flag decode
    unique case (req.op)
      // plain add, carry in held low
      flag_align_pkg::OP_ADD: begin
        arith = 1'b1;
        do_write = 1'b1;
      end
      // add with carry chains multi-precision sums
      flag_align_pkg::OP_ADDX: begin
        arith = 1'b1;
        do_write = 1'b1;
        cin = condition_flags[flag_align_pkg::FLAG_BIT_CARRY];
      end
      // compare runs the subtractor but stores nothing
      flag_align_pkg::OP_SUB, flag_align_pkg::OP_CMP: begin
        arith = 1'b1;
        sub = 1'b1;
        do_write = (req.op == flag_align_pkg::OP_SUB);
      end
      // subtract with the previous carry taken as borrow
      flag_align_pkg::OP_SUBX: begin
        arith = 1'b1;
        sub = 1'b1;
        do_write = 1'b1;
        cin = condition_flags[flag_align_pkg::FLAG_BIT_CARRY];
      end
      flag_align_pkg::OP_NEG: begin
        // negate is zero minus the destination
        arith = 1'b1;
        sub = 1'b1;
        do_write = 1'b1;
        bop = a;
        a = 32'h0000_0000;
      end
      // logic ops and moves clear overflow and keep carry
      flag_align_pkg::OP_AND: begin
        logic_op = 1'b1;
        do_write = 1'b1;
        r = a & b;
      end
      flag_align_pkg::OP_OR: begin
        logic_op = 1'b1;
        do_write = 1'b1;
        r = a | b;
      end
      flag_align_pkg::OP_XOR: begin
        logic_op = 1'b1;
        do_write = 1'b1;
        r = a ^ b;
      end
      flag_align_pkg::OP_MOV: begin
        logic_op = 1'b1;
        do_write = 1'b1;
        r = b;
      end
      // left shifts and rotates lose the top bit into carry
      flag_align_pkg::OP_SHL, flag_align_pkg::OP_ROL: begin
        shift_op = 1'b1;
        do_write = 1'b1;
        sh_out = top_bit(a, req.size);                      // [RL6]
        r = fit({a[30:0], (req.op == flag_align_pkg::OP_ROL) ? sh_out : 1'b0}, req.size);
      end
      // right shifts lose bit 0; the arithmetic shift keeps the sign
      flag_align_pkg::OP_SHR, flag_align_pkg::OP_SAR, flag_align_pkg::OP_ROR: begin
        shift_op = 1'b1;
        do_write = 1'b1;
        sh_out = a[0];                                      // [RL6]
        r = a >> 1;
        if (req.op == flag_align_pkg::OP_SAR) begin
          r = r | (top_bit(a, req.size) ? top_mask(req.size) : 32'h0000_0000);
        end else if (req.op == flag_align_pkg::OP_ROR) begin
          r = r | (sh_out ? top_mask(req.size) : 32'h0000_0000);
        end
      end
      flag_align_pkg::OP_DAA, flag_align_pkg::OP_DAS: begin
        // byte seen as two packed digits; adjust uses the saved half carry and carry
        do_write = 1'b1;
        if (condition_flags[flag_align_pkg::FLAG_BIT_HALF] || a[3:0] > 4'h9)
          dadj[3:0] = 4'h6;                                 // [RL10]
        // high digit also adjusts when the low digit will carry into it
        if (condition_flags[flag_align_pkg::FLAG_BIT_CARRY] || a[7:4] > 4'h9 ||
            (req.op == flag_align_pkg::OP_DAA && a[7:4] == 4'h9 && a[3:0] > 4'h9))
          dadj[7:4] = 4'h6;                                 // [RL10]
        r = fit((req.op == flag_align_pkg::OP_DAA) ? a + {24'h00_0000, dadj}
                                                   : a - {24'h00_0000, dadj},
                flag_align_pkg::SIZE_BYTE);
        next_flags[flag_align_pkg::FLAG_BIT_NEG]  = r[7];
        next_flags[flag_align_pkg::FLAG_BIT_ZERO] = (r[7:0] == 8'h00);
        if (req.op == flag_align_pkg::OP_DAA)
          next_flags[flag_align_pkg::FLAG_BIT_CARRY] =
            condition_flags[flag_align_pkg::FLAG_BIT_CARRY] | dadj[5];
      end
      // bit tests fold one selected bit into the carry accumulator
      flag_align_pkg::OP_BLD:
        next_flags[flag_align_pkg::FLAG_BIT_CARRY] = bit_val;              // [RL7]
      flag_align_pkg::OP_BAND:
        next_flags[flag_align_pkg::FLAG_BIT_CARRY] =
          condition_flags[flag_align_pkg::FLAG_BIT_CARRY] & bit_val;       // [RL7]
      flag_align_pkg::OP_BOR:
        next_flags[flag_align_pkg::FLAG_BIT_CARRY] =
          condition_flags[flag_align_pkg::FLAG_BIT_CARRY] | bit_val;       // [RL7]
      flag_align_pkg::OP_BXOR:
        next_flags[flag_align_pkg::FLAG_BIT_CARRY] =
          condition_flags[flag_align_pkg::FLAG_BIT_CARRY] ^ bit_val;       // [RL7]
      // bit stores return only the rewritten low byte; the upper 24 bits of the result are zero
      flag_align_pkg::OP_BST: begin
        do_write = 1'b1;
        r = {24'h00_0000, condition_flags[flag_align_pkg::FLAG_BIT_CARRY]
               ? (req.dst[7:0] | bmask) : (req.dst[7:0] & ~bmask)};        // [RL7] [RL9]
      end
      flag_align_pkg::OP_BSET: begin
        do_write = 1'b1;
        r = {24'h00_0000, req.dst[7:0] | bmask};            // [RL9]
      end
      flag_align_pkg::OP_BCLR: begin
        do_write = 1'b1;
        r = {24'h00_0000, req.dst[7:0] & ~bmask};           // [RL9]
      end
      flag_align_pkg::OP_BNOT: begin
        do_write = 1'b1;
        r = {24'h00_0000, req.dst[7:0] ^ bmask};            // [RL9]
      end
      // control-register ops rewrite the whole flag byte at once
      flag_align_pkg::OP_FLDC:  next_flags = req.src[7:0];                     // [RL16]
      flag_align_pkg::OP_FANDC: next_flags = condition_flags & req.src[7:0];   // [RL16]
      flag_align_pkg::OP_FORC:  next_flags = condition_flags | req.src[7:0];   // [RL16]
      flag_align_pkg::OP_FXORC: next_flags = condition_flags ^ req.src[7:0];   // [RL16]
      default: begin
        // no operation: every flag holds
        do_write = 1'b0;
      end
    endcase

    // shared adder; subtraction is a plus not-b plus one minus borrow
    if (arith) begin
      if (sub)
        sum = {1'b0, a} + {1'b0, fit(~bop, req.size)} + {32'h0000_0000, ~cin};
      else
        sum = {1'b0, a} + {1'b0, bop} + {32'h0000_0000, cin};
      r = fit(sum[31:0], req.size);
      next_flags[flag_align_pkg::FLAG_BIT_NEG]  = top_bit(r, req.size);           // [RL1]
      // extended ops keep zero clear once cleared, so multi-word zero tests chain
      next_flags[flag_align_pkg::FLAG_BIT_ZERO] = (r == 32'h0000_0000) &&
        ((req.op != flag_align_pkg::OP_ADDX && req.op != flag_align_pkg::OP_SUBX) ||
         condition_flags[flag_align_pkg::FLAG_BIT_ZERO]);                         // [RL2]
      // signed overflow: operands agree in sign, the result does not
      next_flags[flag_align_pkg::FLAG_BIT_OVF] =
        (top_bit(a, req.size) == (top_bit(bop, req.size) ^ sub)) &&
        (top_bit(r, req.size) != top_bit(a, req.size));                          // [RL3]
      // carry out at the operand top, inverted for borrow
      next_flags[flag_align_pkg::FLAG_BIT_CARRY] =
        sub ^ carry_out(sum, req.size);                                          // [RL4] [RL5]
      // half carry is the carry out of the nibble below the top digit
      next_flags[flag_align_pkg::FLAG_BIT_HALF] =
        sub ^ carry_at(a, sub ? fit(~bop, req.size) : bop, sum[31:0], hpos);     // [RL15]
    end else if (logic_op || shift_op) begin
      // logic and shift results set sign and zero the same way
      next_flags[flag_align_pkg::FLAG_BIT_NEG]  = top_bit(r, req.size);           // [RL1] [RL17]
      next_flags[flag_align_pkg::FLAG_BIT_ZERO] = (r == 32'h0000_0000);           // [RL2]
      next_flags[flag_align_pkg::FLAG_BIT_OVF]  = 1'b0;                           // [RL3]
      if (shift_op)
        next_flags[flag_align_pkg::FLAG_BIT_CARRY] = sh_out;                      // [RL6]
    end
  end

  // ==========================================================
  // flag register; updates only on an accepted request
  always_ff @(posedge mclk) begin
    if (rst)
      condition_flags <= flag_align_pkg::FLAG_RESET;
    else if (req_valid)
      condition_flags <= next_flags;                        // [RL16]
  end

  // result register, one cycle after the request
  always_ff @(posedge mclk) begin
    if (rst) begin
      res.value <= 32'h0000_0000;
      res.write <= 1'b0;
    end else begin
      // value follows every cycle; only write marks it as worth storing
      res.value <= r;
      res.write <= req_valid & do_write;
    end
  end

  // ==========================================================
  // alignment: no address error exists, the low bit of word, longword and fetch addresses is simply dropped
  always_comb begin
    mem_addr_out = mem_addr_in;
    // word and longword drop bit 0; byte accesses keep every bit
    if (mem_size != flag_align_pkg::SIZE_BYTE)
      mem_addr_out[0] = 1'b0;                               // [RL12]
  end

  // every instruction is one word long, so fetch is always even
  assign fetch_addr_out = {fetch_addr_in[23:1], 1'b0};      // [RL13]

endmodule

//--- verification/flag_align_chk.sv
// concurrent checks on the ports of the flag and alignment unit
`timescale 1ns/10ps
module flag_align_chk (
  input wire logic                     mclk,
  input wire logic                     rst,
  input wire logic                     req_valid,
  input wire flag_align_pkg::alu_req_s req,
  input wire flag_align_pkg::alu_res_s res,
  input wire logic [7:0]               condition_flags,
  input wire logic [23:0]              mem_addr_in,
  input wire flag_align_pkg::size_e    mem_size,
  input wire logic [23:0]              mem_addr_out,
  input wire logic [23:0]              fetch_addr_in,
  input wire logic [23:0]              fetch_addr_out
);
  // ==========================================================
  // byte expectations captured with each request
  logic [8:0] sum;
  logic [4:0] low;
  logic       bv;
  logic       add_b;
  logic       e_c;
  logic       e_v;
  logic       e_h;
  logic       e_b;
  logic       e_hi;
  logic       e_bit;
  assign sum   = {1'b0, req.dst[7:0]} + {1'b0, req.src[7:0]};
  assign low   = {1'b0, req.dst[3:0]} + {1'b0, req.src[3:0]};
  assign bv    = req_valid && req.size == flag_align_pkg::SIZE_BYTE;
  assign add_b = bv && req.op == flag_align_pkg::OP_ADD;

  // the unit answers one edge later, so expectations are held one cycle
  always_ff @(posedge mclk) begin
    e_c   <= sum[8];
    e_v   <= (req.dst[7] == req.src[7]) && (sum[7] != req.dst[7]);
    e_h   <= low[4];
    e_b   <= req.dst[7:0] < req.src[7:0];
    e_hi  <= req.dst[7];
    e_bit <= req.dst[req.bit_sel];
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // ==========================================================
  // assertions
  fetch_even_a: assert property (fetch_addr_out == {fetch_addr_in[23:1], 1'b0})
    else $error("fetch address not forced even");
  mem_even_a: assert property (mem_size != flag_align_pkg::SIZE_BYTE
    |-> mem_addr_out == {mem_addr_in[23:1], 1'b0}) else $error("word address not even");
  mem_byte_a: assert property (mem_size == flag_align_pkg::SIZE_BYTE
    |-> mem_addr_out == mem_addr_in) else $error("byte address altered");
  flag_hold_a: assert property (!req_valid |=> $stable(condition_flags))
    else $error("flags moved without a request");
  add_carry_a: assert property (add_b |=> condition_flags[0] == e_c)
    else $error("add carry wrong");
  add_ovf_a: assert property (add_b |=> condition_flags[1] == e_v)
    else $error("add overflow wrong");
  add_half_a: assert property (add_b |=> condition_flags[5] == e_h)
    else $error("add half carry wrong");
  sign_zero_a: assert property (add_b |=> condition_flags[3] == res.value[7] &&
    condition_flags[2] == (res.value[7:0] == 8'h00)) else $error("sign or zero wrong");
  sub_borrow_a: assert property (bv && req.op == flag_align_pkg::OP_SUB
    |=> condition_flags[0] == e_b) else $error("subtract borrow wrong");
  shift_out_a: assert property (bv && req.op == flag_align_pkg::OP_SHL
    |=> condition_flags[0] == e_hi) else $error("shifted bit not in carry");
  bit_load_a: assert property (req_valid && req.op == flag_align_pkg::OP_BLD
    |=> condition_flags[0] == e_bit) else $error("bit load wrong");
endmodule

//--- verification/mem_model.sv
// memory behind the aligned operand address
`timescale 1ns/10ps
module mem_model (
  input  wire logic [23:0] addr,
  output logic [15:0]      rdata
);
  // ==========================================================
  // words start at even addresses, high byte first; bytes follow the address
  always_comb begin
    rdata = {addr[7:0] ^ 8'hA5, (addr[7:0] + 8'h01) ^ 8'hA5};
  end
endmodule

//--- verification/testbench.sv
// self-checking bench for the flag and alignment unit
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin fails++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module testbench;
  localparam flag_align_pkg::size_e SB = flag_align_pkg::SIZE_BYTE;
  logic                     mclk;
  logic                     rst;
  logic                     req_valid;
  flag_align_pkg::alu_req_s req;
  flag_align_pkg::alu_res_s res;
  logic [7:0]               condition_flags;
  logic [23:0]              mem_addr_in;
  logic [23:0]              mem_addr_out;
  logic [23:0]              fetch_addr_in;
  logic [23:0]              fetch_addr_out;
  flag_align_pkg::size_e    mem_size;
  logic [15:0]              rdata;
  logic [4:0]               hnzvc;
  int                       fails;
  int                       n_checks;
  int                       cycles = 0;
  assign hnzvc = {condition_flags[5], condition_flags[3:0]};

  flag_align_unit dut (.mclk(mclk), .rst(rst), .req_valid(req_valid), .req(req), .res(res),
    .condition_flags(condition_flags), .mem_addr_in(mem_addr_in), .mem_size(mem_size),
    .mem_addr_out(mem_addr_out), .fetch_addr_in(fetch_addr_in),
    .fetch_addr_out(fetch_addr_out));
  mem_model mem (.addr(mem_addr_out), .rdata(rdata));

  // ==========================================================
  // clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // one request, held a single cycle just after the edge
  task automatic run(input flag_align_pkg::op_e op, input flag_align_pkg::size_e sz,
                     input logic [2:0] sel, input logic [31:0] d, input logic [31:0] s);
    @(posedge mclk);
    #1;
    req = '{op, sz, sel, d, s};
    req_valid = 1'b1;
    @(posedge mclk);
    #1;
    req_valid = 1'b0;
  endtask

  task automatic opchk(input flag_align_pkg::op_e op, input flag_align_pkg::size_e sz,
                       input logic [2:0] sel, input logic [31:0] d, input logic [31:0] s,
                       input logic [31:0] ev, input logic ew, input logic [4:0] ef);
    run(op, sz, sel, d, s);
    `CHK("write", ew, res.write)
    if (ew) `CHK("value", ev, res.value)
    `CHK("flags", ef, hnzvc)
  endtask

  task automatic flagop(input flag_align_pkg::op_e op, input logic [7:0] s, input logic [7:0] ex);
    run(op, SB, 3'h0, 32'h0, {24'h00_0000, s});
    `CHK("flag register", ex, condition_flags)
  endtask

  // ==========================================================
  // main sequence; expected flags are {half, sign, zero, overflow, carry}
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    mem_addr_in = 24'h00_0000;
    mem_size = SB;
    fetch_addr_in = 24'h00_0000;
    fails = 0;
    n_checks = 0;
    repeat (10) @(posedge mclk);
    #1;
    rst = 1'b0;
    `CHK("reset flags", 8'h80, condition_flags)
    opchk(flag_align_pkg::OP_ADD, SB, 3'h0, 32'h7F, 32'h1, 32'h80, 1'b1, 5'h1A);
    opchk(flag_align_pkg::OP_ADD, SB, 3'h0, 32'hFF, 32'h1, 32'h0, 1'b1, 5'h15);
    opchk(flag_align_pkg::OP_ADD, flag_align_pkg::SIZE_WORD, 3'h0, 32'h800, 32'h800,
          32'h1000, 1'b1, 5'h10);
    opchk(flag_align_pkg::OP_ADD, flag_align_pkg::SIZE_WORD, 3'h0, 32'hFFFF, 32'h1,
          32'h0, 1'b1, 5'h15);
    opchk(flag_align_pkg::OP_ADD, flag_align_pkg::SIZE_LONG, 3'h0, 32'h7FFF_FFFF, 32'h1,
          32'h8000_0000, 1'b1, 5'h1A);
    opchk(flag_align_pkg::OP_SUB, SB, 3'h0, 32'h0, 32'h1, 32'hFF, 1'b1, 5'h19);
    opchk(flag_align_pkg::OP_SUB, SB, 3'h0, 32'h80, 32'h1, 32'h7F, 1'b1, 5'h12);
    opchk(flag_align_pkg::OP_CMP, flag_align_pkg::SIZE_LONG, 3'h0, 32'h0, 32'h1,
          32'h0, 1'b0, 5'h19);
    opchk(flag_align_pkg::OP_SHL, SB, 3'h0, 32'h81, 32'h0, 32'h2, 1'b1, 5'h11);
    opchk(flag_align_pkg::OP_SHR, SB, 3'h0, 32'h1, 32'h0, 32'h0, 1'b1, 5'h15);
    opchk(flag_align_pkg::OP_ROR, SB, 3'h0, 32'h1, 32'h0, 32'h80, 1'b1, 5'h19);
    opchk(flag_align_pkg::OP_SAR, flag_align_pkg::SIZE_LONG, 3'h0, 32'h8000_0002, 32'h0,
          32'hC000_0001, 1'b1, 5'h18);
    opchk(flag_align_pkg::OP_ROL, SB, 3'h0, 32'h80, 32'h0, 32'h1, 1'b1, 5'h11);
    opchk(flag_align_pkg::OP_AND, SB, 3'h0, 32'hF0, 32'hF, 32'h0, 1'b1, 5'h15);
    opchk(flag_align_pkg::OP_MOV, SB, 3'h0, 32'h0, 32'h80, 32'h80, 1'b1, 5'h19);
    opchk(flag_align_pkg::OP_NEG, SB, 3'h0, 32'h1, 32'h0, 32'hFF, 1'b1, 5'h19);
    opchk(flag_align_pkg::OP_ADDX, SB, 3'h0, 32'hFF, 32'h0, 32'h0, 1'b1, 5'h11);
    opchk(flag_align_pkg::OP_SUBX, SB, 3'h0, 32'h0, 32'h0, 32'hFF, 1'b1, 5'h19);
    opchk(flag_align_pkg::OP_NONE, SB, 3'h0, 32'h0, 32'h0, 32'h0, 1'b0, 5'h19);
    flagop(flag_align_pkg::OP_FLDC, 8'h00, 8'h00);
    flagop(flag_align_pkg::OP_FORC, 8'h51, 8'h51);
    flagop(flag_align_pkg::OP_FANDC, 8'hF0, 8'h50);
    flagop(flag_align_pkg::OP_FXORC, 8'hFF, 8'hAF);
    flagop(flag_align_pkg::OP_FLDC, 8'h00, 8'h00);
    opchk(flag_align_pkg::OP_BLD, SB, 3'h7, 32'h80, 32'h0, 32'h0, 1'b0, 5'h01);
    opchk(flag_align_pkg::OP_BAND, SB, 3'h1, 32'h1, 32'h0, 32'h0, 1'b0, 5'h00);
    opchk(flag_align_pkg::OP_BOR, SB, 3'h0, 32'h1, 32'h0, 32'h0, 1'b0, 5'h01);
    opchk(flag_align_pkg::OP_BST, SB, 3'h2, 32'h0, 32'h0, 32'h4, 1'b1, 5'h01);
    opchk(flag_align_pkg::OP_BCLR, SB, 3'h0, 32'hFF, 32'h0, 32'hFE, 1'b1, 5'h01);
    opchk(flag_align_pkg::OP_BSET, SB, 3'h7, 32'h0, 32'h0, 32'h80, 1'b1, 5'h01);
    opchk(flag_align_pkg::OP_BXOR, SB, 3'h3, 32'h8, 32'h0, 32'h0, 1'b0, 5'h00);
    opchk(flag_align_pkg::OP_BNOT, SB, 3'h4, 32'h0, 32'h0, 32'h10, 1'b1, 5'h00);
    opchk(flag_align_pkg::OP_ADD, SB, 3'h0, 32'h9, 32'h1, 32'hA, 1'b1, 5'h00);
    opchk(flag_align_pkg::OP_DAA, SB, 3'h0, 32'hA, 32'h0, 32'h10, 1'b1, 5'h00);
    opchk(flag_align_pkg::OP_SUB, SB, 3'h0, 32'h10, 32'h1, 32'hF, 1'b1, 5'h10);
    opchk(flag_align_pkg::OP_DAS, SB, 3'h0, 32'hF, 32'h0, 32'h9, 1'b1, 5'h10);
    // odd operand and fetch addresses fall back to the even address below
    mem_addr_in = 24'h00_0123;
    mem_size = flag_align_pkg::SIZE_WORD;
    fetch_addr_in = 24'h00_0457;
    @(posedge mclk);
    #1;
    `CHK("word address", 24'h00_0122, mem_addr_out)
    `CHK("word data", {8'h22 ^ 8'hA5, 8'h23 ^ 8'hA5}, rdata)
    `CHK("fetch address", 24'h00_0456, fetch_addr_out)
    mem_size = flag_align_pkg::SIZE_LONG;
    @(posedge mclk);
    #1;
    `CHK("long address", 24'h00_0122, mem_addr_out)
    // stack pushes and pops stay word sized, so the even pointer passes unchanged
    mem_addr_in = 24'h00_FFFE;
    mem_size = flag_align_pkg::SIZE_WORD;
    @(posedge mclk);
    #1;
    `CHK("stack address", 24'h00_FFFE, mem_addr_out)
    `CHK("stack data", {8'hFE ^ 8'hA5, 8'hFF ^ 8'hA5}, rdata)
    mem_addr_in = 24'h00_0123;
    mem_size = SB;
    @(posedge mclk);
    #1;
    `CHK("byte address", 24'h00_0123, mem_addr_out)
    // a second reset in mid-run restores the mask-only flag value
    @(posedge mclk);
    #1;
    rst = 1'b1;
    @(posedge mclk);
    #1;
    rst = 1'b0;
    `CHK("second reset flags", 8'h80, condition_flags)
    report_and_stop();
  end
endmodule

bind flag_align_unit flag_align_chk chk (.mclk(mclk), .rst(rst), .req_valid(req_valid),
  .req(req), .res(res), .condition_flags(condition_flags), .mem_addr_in(mem_addr_in),
  .mem_size(mem_size), .mem_addr_out(mem_addr_out), .fetch_addr_in(fetch_addr_in),
  .fetch_addr_out(fetch_addr_out));
